// [src/plr_consts.svh]
// register offsets, field positions and reset values of the port management bank
// assumes the includer uses the index values: byte address = 4 * register index
`ifndef PLR_CONSTS_SVH
`define PLR_CONSTS_SVH

// ************************************************************
// register indexes (byte address is four times these)
// ************************************************************
`define PLR_IDX_IRQ_STATUS 5'h1a
`define PLR_IDX_AUX 5'h1c
`define PLR_IDX_LED_MODE 5'h1d
`define PLR_IDX_LED_BEHAV 5'h1e
`define PLR_IDX_PAGE 5'h1f
`define PLR_IDX_SERDES_AN 5'h10
`define PLR_IDX_LAST_PAGED 5'h1e

// ************************************************************
// page select values
// ************************************************************
`define PLR_PAGE_MAIN 16'h0000
`define PLR_PAGE_EXT 16'h0001
`define PLR_PAGE_GPIO 16'h0010

// ************************************************************
// field positions
// ************************************************************
`define PLR_AUX_AN_DONE 15
`define PLR_AUX_AN_OFF 14
`define PLR_AUX_TMO_HI 7
`define PLR_AUX_PSAVE 6
`define PLR_AUX_FDX 5
`define PLR_AUX_TMO_LO 2
`define PLR_BEH_COPPER_ONLY 15
`define PLR_BEH_SPLIT_ACT 14
`define PLR_SD_TXRF_HI 15
`define PLR_SD_PDET 11
`define PLR_IRQ_PEND 15

// ************************************************************
// reset values and masks
// ************************************************************
`define PLR_RST_ZERO 16'h0000
`define PLR_IRQ_EVT_MASK 16'h7e16
`define PLR_BEH_RW_MASK 16'hc00f

`endif

// [src/plr_pkg.sv]
// types shared by the port management bank
// assumes plr_consts.svh supplies the numbers
package plr_pkg;
   // strap capture sequence, gray coded along the path
   typedef enum logic [1:0] {
      PLR_ST_WAIT = 2'b00,
      PLR_ST_LOAD = 2'b01,
      PLR_ST_DONE = 2'b11
   } plr_strap_st_t;
   // resolved link speed code
   typedef enum logic [1:0] {
      PLR_SPD_10 = 2'b00,
      PLR_SPD_100 = 2'b01,
      PLR_SPD_1000 = 2'b10,
      PLR_SPD_RSVD = 2'b11
   } plr_speed_t;
endpackage

// [src/plr_regs.sv]
// management register bank of one port: auxiliary status, leds, page select, serdes an
// assumes an apb master on i_sys_clk and phy core status inputs on the same clock
//
// Functional notes
// - aux bit 15 mirrors an-complete status
// - aux bit 14 is inverted an-enable
// - bits 13..8 report crossover, swap, polarities
// - timeout code from bits 7 and 2
// - bit 6 enables link power saving
// - bits 4:3 speed, bit 5 duplex
// - four 4-bit led mode fields, strapped
// - codes 0..7 link with activity variants
// - codes 8..11 duplex, collision, activity, fiber
// - code 12 an fault, 13 serial (code 13 drives the led off here)
// - code 14 forced off, 15 forced on
// - behaviour bit 15 restricts link to copper
// - split bit makes tx/rx activity separate
// - bits 3:0 disable combined led indications
// - mode bits 11:10 set by first port only
// - page 0x0001 maps 16..30 to extended
// - addresses 0..15 unaffected except gpio page
// - page register resets to zero
// - page 0x0010 maps 0..30 to gpio
// - serdes bits 15:14 transmit remote fault
// - serdes bits 13:12 partner remote fault
// - bit 11 parallel detect, bit 10 signal detect
// - interrupt status clears when read
//
// Design decision made here: the APB interface to the registers.
`include "plr_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module plr_regs
   import plr_pkg::*;
#(
   parameter bit FIRST_PORT = 1'b1, // this instance is the first port
   parameter int ADDR_W = 8 // apb address width
) (
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic [20:0] i_strap_configuration_pins, // led modes, combine, timeout msb
   input wire logic i_an_complete,
   input wire logic i_an_enable,
   input wire logic i_crossover,
   input wire logic i_cd_swap,
   input wire logic [3:0] i_pol_inv, // pairs d..a in bits 3..0
   input wire logic [1:0] i_speed,
   input wire logic i_full_duplex_flag,
   input wire logic i_copper_link,
   input wire logic i_fiber_link,
   input wire logic i_tx_activity,
   input wire logic i_rx_activity,
   input wire logic i_collision,
   input wire logic i_an_fault,
   input wire logic [1:0] i_far_end_partner_rfault,
   input wire logic i_signal_detect,
   input wire logic [15:0] i_irq_event, // one-cycle event pulses
   input wire logic [1:0] i_shared_led_bits, // mode bits 11:10 held by the first port
   output logic [1:0] o_shared_led_bits,
   output logic o_psave_en,
   output logic [1:0] o_psave_timeout,
   output logic [1:0] o_tx_remote_fault,
   output logic o_parallel_detect_en,
   output logic o_indicator_output_zero,
   output logic o_indicator_output_one,
   output logic o_indicator_output_two,
   output logic o_indicator_output_three
);

   // ************************************************************
   // apb decode
   // ************************************************************
   logic setup_w; // first cycle of a transfer
   logic done_w; // completing edge of a transfer
   logic [4:0] idx_w; // register index
   logic bad_addr_w; // address above the 32 registers
   logic [15:0] page_reg; // page select register
   logic pg_ext_w; // extended page active
   logic pg_gpio_w; // gpio page active
   logic main_w; // access hits a main register of this bank
   logic ext_w; // access hits an extended register of this bank
   logic pready_reg;
   logic pslverr_reg;
   logic [31:0] prdata_reg;

   assign setup_w = i_psel & ~i_penable;
   assign done_w = i_psel & i_penable & pready_reg;
   assign idx_w = i_paddr[6:2];
   assign bad_addr_w = |i_paddr[ADDR_W-1:7];
   assign pg_ext_w = (page_reg == `PLR_PAGE_EXT);
   assign pg_gpio_w = (page_reg == `PLR_PAGE_GPIO);
   // address 31 always reaches the page register; unknown pages act as main
   assign main_w = !bad_addr_w && ((idx_w == `PLR_IDX_PAGE) ||
                   (!pg_gpio_w && !(pg_ext_w && idx_w >= 5'h10)));
   assign ext_w = !bad_addr_w && pg_ext_w && idx_w >= 5'h10 &&
                  idx_w <= `PLR_IDX_LAST_PAGED;

   logic wr_w; // write taken at this edge
   logic rd_w; // read taken at this edge
   assign wr_w = done_w & i_pwrite;
   assign rd_w = done_w & ~i_pwrite;

   // ************************************************************
   // strap capture after reset release
   // ************************************************************
   logic [20:0] strap_s1_reg, strap_s2_reg, strap_s3_reg; // pin synchroniser stages
   logic [1:0] fill_reg; // edges since reset, stops at three once stage three holds pins
   plr_strap_st_t strap_st_reg;
   logic strap_load_w; // one cycle: copy straps into the strap-reset fields

   // three stage synchroniser, the first stage feeds only the second
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         strap_s1_reg <= '0;
         strap_s2_reg <= '0;
         strap_s3_reg <= '0;
         fill_reg <= 2'h0;
      end else begin
         // reset zeros in stages two and three agree as well, so wait for real samples
         if (fill_reg != 2'h3) begin
            fill_reg <= fill_reg + 2'h1;
         end
         strap_s1_reg <= i_strap_configuration_pins;
         strap_s2_reg <= strap_s1_reg;
         strap_s3_reg <= strap_s2_reg;
      end
   end

   // wait until the synchroniser is full and settled, then load once
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         strap_st_reg <= PLR_ST_WAIT;
      end else begin
         case (strap_st_reg)
            PLR_ST_WAIT: begin
               if (fill_reg == 2'h3 && strap_s2_reg == strap_s3_reg) begin
                  strap_st_reg <= PLR_ST_LOAD;
               end
            end
            PLR_ST_LOAD: strap_st_reg <= PLR_ST_DONE;
            PLR_ST_DONE: strap_st_reg <= PLR_ST_DONE;
            default: strap_st_reg <= PLR_ST_WAIT;
         endcase
      end
   end
   assign strap_load_w = (strap_st_reg == PLR_ST_LOAD);

   // ************************************************************
   // writable registers
   // ************************************************************
   logic [15:0] led_mode_reg;
   logic [15:0] led_beh_reg;
   logic psave_en_reg;
   logic [1:0] psave_tmo_reg;
   logic [1:0] tx_rf_reg;
   logic pdet_reg;

   // page select; any value is stored as written
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         page_reg <= `PLR_RST_ZERO;
      end else if (wr_w && !bad_addr_w && idx_w == `PLR_IDX_PAGE) begin
         page_reg <= i_pwdata[15:0];
      end
   end

   // led mode; a strap load replaces the reset value, a write wins over it
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         led_mode_reg <= `PLR_RST_ZERO;
      end else if (wr_w && main_w && idx_w == `PLR_IDX_LED_MODE) begin
         led_mode_reg[15:12] <= i_pwdata[15:12];
         led_mode_reg[9:0] <= i_pwdata[9:0];
         if (FIRST_PORT) begin
            led_mode_reg[11:10] <= i_pwdata[11:10];
         end
      end else if (strap_load_w) begin
         led_mode_reg <= strap_s3_reg[15:0];
      end
   end

   // led behaviour
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         led_beh_reg <= `PLR_RST_ZERO;
      end else if (wr_w && main_w && idx_w == `PLR_IDX_LED_BEHAV) begin
         led_beh_reg <= i_pwdata[15:0] & `PLR_BEH_RW_MASK;
      end else if (strap_load_w) begin
         led_beh_reg[3:0] <= strap_s3_reg[19:16];
      end
   end

   // auxiliary control fields
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         psave_en_reg <= 1'b0;
         psave_tmo_reg <= 2'b00;
      end else if (wr_w && main_w && idx_w == `PLR_IDX_AUX) begin
         psave_en_reg <= i_pwdata[`PLR_AUX_PSAVE];
         psave_tmo_reg <= {i_pwdata[`PLR_AUX_TMO_HI], i_pwdata[`PLR_AUX_TMO_LO]};
      end else if (strap_load_w) begin
         psave_tmo_reg[1] <= strap_s3_reg[20];
      end
   end

   // serdes media auto-negotiation control
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         tx_rf_reg <= 2'b00;
         pdet_reg <= 1'b0;
      end else if (wr_w && ext_w && idx_w == `PLR_IDX_SERDES_AN) begin
         tx_rf_reg <= i_pwdata[`PLR_SD_TXRF_HI -: 2];
         pdet_reg <= i_pwdata[`PLR_SD_PDET];
      end
   end

   // ************************************************************
   // interrupt status: sticky, cleared by a read, an event wins
   // ************************************************************
   logic [15:0] irq_reg;
   logic irq_rd_w;
   assign irq_rd_w = rd_w && main_w && idx_w == `PLR_IDX_IRQ_STATUS;

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         irq_reg <= `PLR_RST_ZERO;
      end else begin
         // a read clears only what its setup snapshot reported; a later event stays pending
         irq_reg <= ((irq_rd_w ? (irq_reg & ~prdata_reg[15:0]) : irq_reg) | i_irq_event) &
                    `PLR_IRQ_EVT_MASK;
      end
   end

   // ************************************************************
   // read data
   // ************************************************************
   logic [15:0] led_eff_w; // led modes with the shared field applied
   logic [15:0] aux_w;
   logic [15:0] sd_w;
   logic [15:0] rd_mux_w;

   assign led_eff_w = FIRST_PORT ? led_mode_reg :
                      {led_mode_reg[15:12], i_shared_led_bits, led_mode_reg[9:0]};
   assign aux_w = {i_an_complete,
                   ~i_an_enable,
                   i_crossover, i_cd_swap, i_pol_inv[0], i_pol_inv[1],
                   i_pol_inv[2], i_pol_inv[3],
                   psave_tmo_reg[1], psave_en_reg,
                   i_full_duplex_flag, i_speed,
                   psave_tmo_reg[0], 2'b00};
   assign sd_w = {tx_rf_reg, i_far_end_partner_rfault, pdet_reg, i_signal_detect,
                  10'h000};

   // registers of other blocks and pages read as zero here
   always_comb begin
      rd_mux_w = 16'h0000;
      if (main_w) begin
         case (idx_w)
            `PLR_IDX_IRQ_STATUS: rd_mux_w = {|irq_reg, irq_reg[14:0]};
            `PLR_IDX_AUX: rd_mux_w = aux_w;
            `PLR_IDX_LED_MODE: rd_mux_w = led_eff_w;
            `PLR_IDX_LED_BEHAV: rd_mux_w = led_beh_reg;
            `PLR_IDX_PAGE: rd_mux_w = page_reg;
            default: rd_mux_w = 16'h0000;
         endcase
      end else if (ext_w && idx_w == `PLR_IDX_SERDES_AN) begin
         rd_mux_w = sd_w;
      end
   end

   // data captured in setup, ready in the single access cycle
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         pready_reg <= setup_w;
         if (setup_w) begin
            pslverr_reg <= bad_addr_w;
            prdata_reg <= {16'h0000, rd_mux_w};
         end else if (done_w) begin
            pslverr_reg <= 1'b0;
         end
      end
   end

   // ************************************************************
   // led drive
   // ************************************************************
   // blink timing is outside this bank: combined modes drop while the event is seen
   function automatic logic led_eval(input logic [3:0] mode, input logic cdis,
                                     input logic [15:0] beh);
      logic lnk, fib, act, fact; // link, fiber link, activity, fiber activity
      logic spd10, spd100, spd1000, r;
      lnk = i_copper_link | (i_fiber_link & ~beh[`PLR_BEH_COPPER_ONLY]);
      fib = i_fiber_link;
      act = beh[`PLR_BEH_SPLIT_ACT] ? i_tx_activity :
            (i_tx_activity | i_rx_activity);
      fact = beh[`PLR_BEH_SPLIT_ACT] ? i_rx_activity :
             (i_tx_activity | i_rx_activity);
      spd10 = (i_speed == PLR_SPD_10);
      spd100 = (i_speed == PLR_SPD_100);
      spd1000 = (i_speed == PLR_SPD_1000);
      r = 1'b0;
      case (mode)
         4'h0: r = lnk;
         4'h1: r = lnk & spd1000;
         4'h2: r = lnk & spd100;
         4'h3: r = lnk & spd10;
         4'h4: r = lnk & (spd100 | spd1000);
         4'h5: r = lnk & (spd10 | spd1000);
         4'h6: r = lnk & (spd10 | spd100);
         4'h7: r = fib & (spd100 | spd1000);
         4'h8: r = i_full_duplex_flag;
         4'h9: r = i_collision;
         4'ha: r = act;
         4'hb: r = fib;
         4'hc: r = i_an_fault;
         4'hd: r = 1'b0;
         4'he: r = 1'b0;
         4'hf: r = 1'b1;
         default: r = 1'b0;
      endcase
      // combined indications drop during activity or collision
      if (!cdis) begin
         if (mode <= 4'h7 || mode == 4'hb) begin
            r = r & ~((mode == 4'hb) ? fact : act);
         end else if (mode == 4'h8) begin
            r = r & ~i_collision;
         end
      end
      return r;
   endfunction

   logic [3:0] led_reg;
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_led
         always_ff @(posedge i_sys_clk or negedge i_rstn) begin
            if (!i_rstn) begin
               led_reg[g] <= 1'b0;
            end else begin
               led_reg[g] <= led_eval(led_eff_w[4*g +: 4], led_beh_reg[g], led_beh_reg);
            end
         end
      end
   endgenerate

   // ************************************************************
   // outputs
   // ************************************************************
   assign o_prdata = prdata_reg;
   assign o_pready = pready_reg;
   assign o_pslverr = pslverr_reg;
   assign o_shared_led_bits = led_mode_reg[11:10];
   assign o_psave_en = psave_en_reg;
   assign o_psave_timeout = psave_tmo_reg;
   assign o_tx_remote_fault = tx_rf_reg;
   assign o_parallel_detect_en = pdet_reg;
   assign o_indicator_output_zero = led_reg[0];
   assign o_indicator_output_one = led_reg[1];
   assign o_indicator_output_two = led_reg[2];
   assign o_indicator_output_three = led_reg[3];

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);

   sequence s_setup_idx(logic [4:0] ix);
      setup_w && main_w && idx_w == ix;
   endsequence

   AST_AUX_MIRROR: assert property (s_setup_idx(`PLR_IDX_AUX) |=>
      o_prdata[15] == $past(i_an_complete) && o_pready)
      else $error("aux bit 15 does not mirror an complete");
   AST_AUX_AN_OFF: assert property (s_setup_idx(`PLR_IDX_AUX) |=>
      o_prdata[14] == !$past(i_an_enable))
      else $error("aux bit 14 not inverse of an enable");
   AST_PAGE_WRITE: assert property (wr_w && !bad_addr_w && idx_w == `PLR_IDX_PAGE |=>
      page_reg == $past(i_pwdata[15:0]))
      else $error("page register did not take written value");
   AST_PSAVE_WRITE: assert property (wr_w && main_w && idx_w == `PLR_IDX_AUX |=>
      o_psave_en == $past(i_pwdata[6]) &&
      o_psave_timeout == {$past(i_pwdata[7]), $past(i_pwdata[2])})
      else $error("power saving fields not written");
   AST_EXT_WRITE: assert property (wr_w && ext_w && idx_w == `PLR_IDX_SERDES_AN |=>
      o_tx_remote_fault == $past(i_pwdata[15:14]))
      else $error("transmit remote fault not written");
   AST_GPIO_HIDES: assert property (pg_gpio_w && wr_w && idx_w == `PLR_IDX_LED_MODE |=>
      $stable(led_mode_reg))
      else $error("gpio page write reached main register");
   AST_IRQ_CLEAR: assert property (irq_rd_w && i_irq_event == 16'h0000 |=>
      (irq_reg & $past(prdata_reg[15:0])) == 16'h0000)
      else $error("interrupt status not cleared by read");
   AST_IRQ_SET_WINS: assert property (irq_rd_w && i_irq_event[13] |=> irq_reg[13])
      else $error("event lost in clearing read");
   AST_FORCE_ON: assert property (led_eff_w[3:0] == 4'hf |=> o_indicator_output_zero)
      else $error("forced on led is dark");
   AST_FORCE_OFF: assert property (led_eff_w[15:12] == 4'he |=> !o_indicator_output_three)
      else $error("forced off led is lit");
   AST_SHARED_BITS: assert property (!FIRST_PORT && wr_w |=> $stable(led_mode_reg[11:10]))
      else $error("shared led bits written on another port");
   AST_PAGE_RESET: assert property ($rose(i_rstn) |-> page_reg == `PLR_RST_ZERO)
      else $error("page register not zero after reset");

endmodule
`default_nettype wire

// [bench/plr_apb_host.sv]
// station management host model: apb master that reads and writes the port bank
// assumes one rising-edge clock shared with the bank and one transfer at a time
`timescale 1ns/1ns
`default_nettype none

// ************************************************************
// apb master
// ************************************************************
module plr_apb_host (
   input wire logic i_clk,
   input wire logic i_pready,
   output logic o_psel,
   output logic o_penable,
   output logic o_pwrite,
   output logic [7:0] o_paddr,
   output logic [31:0] o_pwdata
);
   // idle bus until the first transfer
   initial begin
      o_psel = 1'b0;
      o_penable = 1'b0;
      o_pwrite = 1'b0;
      o_paddr = 8'h00;
      o_pwdata = 32'h0;
   end

   // setup cycle, then access held until pready is seen at a rising edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      o_psel <= 1'b1;
      o_penable <= 1'b0;
      o_pwrite <= w;
      o_paddr <= a;
      o_pwdata <= d;
      @(posedge i_clk);
      o_penable <= 1'b1;
      // no assumed latency: only the bench watchdog ends a dead transfer
      do begin
         @(posedge i_clk);
      end while (i_pready !== 1'b1);
      o_psel <= 1'b0;
      o_penable <= 1'b0;
      // released lines show no stale value
      o_paddr <= ~a;
      o_pwdata <= ~d;
   endtask
endmodule
`default_nettype wire

// [bench/testbench.sv]
// self-checking bench of the port management bank, host model on apb
// assumes FIRST_PORT=1 and the index-times-four address map of the bank
`include "plr_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module testbench
   import plr_pkg::*;
;
   localparam logic [15:0] LED_ON_TAB = 16'h9133; // mode codes lit in the led scenario
   logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr, psave_en, pdet_en;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [19:0] st; // status levels driven into the bank
   logic [20:0] strap;
   logic [15:0] irq_ev;
   logic [1:0] shared_in, shared_out, psave_to, tx_rf, tmo_m, txrf_m;
   logic [3:0] leds;
   logic psave_m, pdet_m;
   logic [32:0] exp_q[$]; // {pslverr expected, read data}
   int n_fail, checked, seed;

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   plr_regs #(.FIRST_PORT(1'b1), .ADDR_W(8)) i_dut (
      .i_sys_clk(sys_clk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_strap_configuration_pins(strap),
      .i_an_complete(st[0]), .i_an_enable(st[1]), .i_crossover(st[2]), .i_cd_swap(st[3]),
      .i_pol_inv(st[7:4]), .i_speed(st[9:8]), .i_full_duplex_flag(st[10]),
      .i_copper_link(st[11]), .i_fiber_link(st[12]), .i_tx_activity(st[13]),
      .i_rx_activity(st[14]), .i_collision(st[15]), .i_an_fault(st[16]),
      .i_far_end_partner_rfault(st[18:17]), .i_signal_detect(st[19]),
      .i_irq_event(irq_ev), .i_shared_led_bits(shared_in), .o_shared_led_bits(shared_out),
      .o_psave_en(psave_en), .o_psave_timeout(psave_to), .o_tx_remote_fault(tx_rf),
      .o_parallel_detect_en(pdet_en), .o_indicator_output_zero(leds[0]),
      .o_indicator_output_one(leds[1]), .o_indicator_output_two(leds[2]),
      .o_indicator_output_three(leds[3]));

   plr_apb_host i_host (.i_clk(sys_clk), .i_pready(pready), .o_psel(psel),
      .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata));

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic [15:0] aux_exp();
      return {st[0], ~st[1], st[2], st[3], st[4], st[5], st[6], st[7], tmo_m[1], psave_m,
              st[10], st[9:8], tmo_m[0], 2'b00};
   endfunction

   function automatic logic [15:0] sd_exp();
      return {txrf_m, st[18:17], pdet_m, st[19], 10'h0};
   endfunction

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask

   // reads note their expectation first; the monitor compares at pready
   task automatic rd(input logic [4:0] idx, input logic [15:0] d);
      exp_q.push_back({17'h0, d});
      i_host.xfer(1'b0, {1'b0, idx, 2'b00}, 32'h0);
   endtask

   task automatic wr(input logic [4:0] idx, input logic [15:0] d);
      i_host.xfer(1'b1, {1'b0, idx, 2'b00}, {16'($random(seed)), d});
   endtask

   // new status lands on one edge, visible after the next
   task automatic set_st(input logic [19:0] v);
      @(posedge sys_clk);
      st <= v;
      @(posedge sys_clk);
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // read monitor: oldest note against what the bank answers
   always @(posedge sys_clk) begin : mon_blk
      logic [32:0] e;
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h0;
         checked++;
         if (e[32] ? (pslverr !== 1'b1) : ({pslverr, prdata} !== e)) begin
            n_fail++;
            $display("mismatch read exp %h got %h", e, {pslverr, prdata});
         end
      end
   end

   // hang guard, far beyond the 68 transfers of the run
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_fail++;
      end_of_test();
   end

   // ************************************************************
   // scenarios
   // ************************************************************
   initial begin
      seed = 32'he4f89ab5;
      rstn = 1'b0;
      st = 20'h0;
      irq_ev = 16'h0;
      shared_in = 2'b00;
      strap = 21'($random(seed));
      tmo_m = {strap[20], 1'b0};
      psave_m = 1'b0;
      txrf_m = 2'b00;
      pdet_m = 1'b0;
      repeat (20) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (8) @(posedge sys_clk);
      set_st(20'($random(seed)));
      rd(`PLR_IDX_AUX, aux_exp());
      rd(`PLR_IDX_LED_MODE, strap[15:0]);
      rd(`PLR_IDX_LED_BEHAV, {12'h0, strap[19:16]});
      rd(`PLR_IDX_PAGE, `PLR_PAGE_MAIN);
      // status bits must ignore the write, control bits take it
      wr(`PLR_IDX_AUX, 16'hffff);
      tmo_m = 2'b11;
      psave_m = 1'b1;
      set_st(20'($random(seed)));
      rd(`PLR_IDX_AUX, aux_exp());
      chk("psave_en", 16'h1, {15'h0, psave_en});
      wr(`PLR_IDX_AUX, 16'h0004);
      tmo_m = 2'b01;
      psave_m = 1'b0;
      rd(`PLR_IDX_AUX, aux_exp());
      chk("timeout", 16'h1, {14'h0, psave_to});
      wr(`PLR_IDX_LED_BEHAV, 16'hffff);
      rd(`PLR_IDX_LED_BEHAV, `PLR_BEH_RW_MASK);
      // copper gigabit link, full duplex, an fault, no traffic: every code once
      set_st({4'h1, 5'h01, 1'b1, PLR_SPD_1000, 8'h00});
      for (int c = 0; c < 16; c++) begin
         wr(`PLR_IDX_LED_MODE, {4{c[3:0]}});
         rd(`PLR_IDX_LED_MODE, {4{c[3:0]}});
         chk("leds", {12'h0, {4{LED_ON_TAB[c]}}}, {12'h0, leds});
         chk("shared_bits", {14'h0, c[3:2]}, {14'h0, shared_out});
      end
      // fiber-only link is hidden while copper-only is selected
      wr(`PLR_IDX_LED_MODE, 16'h0000);
      set_st(20'h01000);
      repeat (2) @(posedge sys_clk);
      chk("leds_copper", 16'h0, {12'h0, leds});
      wr(`PLR_IDX_LED_BEHAV, 16'h000f);
      repeat (2) @(posedge sys_clk);
      chk("leds_fiber", 16'hf, {12'h0, leds});
      // combined indication goes dark on traffic; split activity shows tx only
      wr(`PLR_IDX_LED_BEHAV, 16'h0000);
      set_st(20'h05000);
      repeat (2) @(posedge sys_clk);
      chk("leds_comb", 16'h0, {12'h0, leds});
      wr(`PLR_IDX_LED_BEHAV, 16'h4000);
      repeat (2) @(posedge sys_clk);
      chk("leds_split", 16'hf, {12'h0, leds});
      // extended page: serdes register
      wr(`PLR_IDX_PAGE, `PLR_PAGE_EXT);
      set_st(20'($random(seed)));
      rd(`PLR_IDX_SERDES_AN, sd_exp());
      rd(`PLR_IDX_AUX, 16'h0);
      wr(`PLR_IDX_SERDES_AN, 16'hffff);
      txrf_m = 2'b11;
      pdet_m = 1'b1;
      rd(`PLR_IDX_SERDES_AN, sd_exp());
      chk("tx_rfault", 16'h3, {14'h0, tx_rf});
      chk("pdet_en", 16'h1, {15'h0, pdet_en});
      wr(`PLR_IDX_PAGE, `PLR_PAGE_GPIO);
      wr(`PLR_IDX_LED_MODE, 16'h5555);
      rd(`PLR_IDX_AUX, 16'h0);
      rd(`PLR_IDX_PAGE, `PLR_PAGE_GPIO);
      wr(`PLR_IDX_PAGE, 16'h0005);
      rd(`PLR_IDX_PAGE, 16'h0005);
      rd(`PLR_IDX_AUX, aux_exp());
      wr(`PLR_IDX_PAGE, `PLR_PAGE_MAIN);
      rd(`PLR_IDX_SERDES_AN, 16'h0);
      rd(`PLR_IDX_LED_MODE, 16'h0000);
      // address outside the bank is refused
      exp_q.push_back({1'b1, 32'h0});
      i_host.xfer(1'b0, 8'hf0, 32'h0);
      // interrupt status clears on read
      @(posedge sys_clk);
      irq_ev <= 16'h2000;
      @(posedge sys_clk);
      irq_ev <= 16'h0;
      rd(`PLR_IDX_IRQ_STATUS, 16'ha000);
      rd(`PLR_IDX_IRQ_STATUS, 16'h0);
      // second reset in mid-run restores page and control bits
      wr(`PLR_IDX_AUX, 16'h0040);
      wr(`PLR_IDX_PAGE, `PLR_PAGE_EXT);
      @(posedge sys_clk);
      rstn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (8) @(posedge sys_clk);
      tmo_m = {strap[20], 1'b0};
      psave_m = 1'b0;
      rd(`PLR_IDX_PAGE, `PLR_PAGE_MAIN);
      rd(`PLR_IDX_AUX, aux_exp());
      chk("psave_rst", 16'h0, {15'h0, psave_en});
      repeat (4) @(posedge sys_clk);
      end_of_test();
   end
endmodule
`default_nettype wire
